/* File: design/prs_pkg.sv */
// package of constants for the power-up and reset sequencer
package prs_pkg;
  localparam int unsigned CLK_PERIOD_PS = 50000;
  // power_up_init_time, longest allowed, in microseconds
  localparam int unsigned POWER_UP_INIT_TIME_US = 150;
  localparam int unsigned POWER_UP_INIT_CYCLES =
    (POWER_UP_INIT_TIME_US * 1000000) / CLK_PERIOD_PS;
  // host-side figures, kept for reference of the far end
  localparam int unsigned RESET_PULSE_WIDTH_NS = 200;
  localparam int unsigned RESET_RELEASE_TO_SELECT_TIME_NS = 200;
  localparam int unsigned RESET_ASSERT_TO_SELECT_TIME_NS = 400;
  localparam int unsigned SUPPLY_OFF_DURATION_US = 50;
  // refresh row counter layout
  localparam int unsigned ROW_W = 13;
  localparam logic [ROW_W-1:0] ROW_RESET = 13'h0000;
  // refresh request pacing, in clock cycles
  localparam int unsigned REFRESH_INTERVAL_CYCLES = 78;
  // configuration register defaults
  localparam logic [15:0] CFG0_RESET = 16'h8f1f;
  localparam logic [15:0] CFG1_RESET = 16'h0002;
  typedef enum logic [2:0] {
    PRS_OFF, PRS_HOLD, PRS_INIT, PRS_STANDBY, PRS_SLEEP, PRS_DEEP_DOWN
  } prs_state_e;
endpackage : prs_pkg

/* File: design/prs_refresh_counter.sv */
// self-refresh row counter with request pacing
`timescale 1ns/1ps
`default_nettype none
module prs_refresh_counter #(
  parameter int unsigned ROWS     = 8192,
  parameter int unsigned INTERVAL = prs_pkg::REFRESH_INTERVAL_CYCLES
) (
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  input  wire logic                     run,
  input  wire logic                     restart,
  output logic                          refresh_pulse,
  output logic [prs_pkg::ROW_W-1:0]     row
);
  import prs_pkg::*;
  // the tick counter is 16 bits wide and the row counter ROW_W bits
  if (ROWS < 1 || ROWS > (1 << ROW_W) || INTERVAL < 1 ||
      INTERVAL > 32'h00010000) begin : g_bad_params
    $error("prs_refresh_counter: unsupported parameters");
  end
  logic [15:0]      tick_q;
  logic [ROW_W-1:0] row_q;
  logic             pulse_q;
  wire              tick_done = (tick_q == 16'(INTERVAL - 1));
  wire              row_wrap  = (row_q == ROW_W'(ROWS - 1));
  // pacing and row advance; restart wins so refresh resumes from row zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_q  <= 16'h0000;
      row_q   <= ROW_RESET;
      pulse_q <= 1'b0;
    end else if (restart) begin
      tick_q  <= 16'h0000;
      row_q   <= ROW_RESET;
      pulse_q <= 1'b0;
    end else if (run) begin
      tick_q  <= tick_done ? 16'h0000 : tick_q + 16'h0001;
      pulse_q <= tick_done;
      if (pulse_q)
        row_q <= row_wrap ? ROW_RESET : row_q + ROW_W'(1);
    end else begin
      pulse_q <= 1'b0;
    end
  end
  assign refresh_pulse = pulse_q;
  assign row           = row_q;
endmodule : prs_refresh_counter
`default_nettype wire

/* File: design/prs_sequencer.sv */
// device-side power-up and hardware reset sequencer
// Behaviour
// - after supply is good, finish self-initialization within 150 us
// - reset low at power-up postpones the init interval until release
// - reset returns the device to standby from any state
// - reset restores every configuration register to its default
// - reset low halts self-refresh, marks array invalid; release restarts
// - reset returns the refresh row counter to its starting row
// - reset forces exit from hybrid sleep and deep power-down
`timescale 1ns/1ps
`default_nettype none
module prs_sequencer #(
  parameter int unsigned INIT_CYCLES = prs_pkg::POWER_UP_INIT_CYCLES,
  parameter int unsigned ROWS        = 8192
) (
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  input  wire logic                     supply_good,
  input  wire logic                     hw_reset_n,
  input  wire logic                     cs_n,
  input  wire logic                     sleep_req,
  input  wire logic                     deep_down_req,
  input  wire logic                     wake_req,
  input  wire logic                     cfg_we,
  input  wire logic                     cfg_sel,
  input  wire logic [15:0]              cfg_wdata,
  output logic                          ready,
  output logic                          array_valid,
  output logic                          refresh_active,
  output logic                          refresh_pulse,
  output logic [prs_pkg::ROW_W-1:0]     refresh_row,
  output logic                          in_sleep,
  output logic                          in_deep_down,
  output logic                          early_select,
  output logic [15:0]                   cfg0,
  output logic [15:0]                   cfg1
);
  import prs_pkg::*;
  // the init countdown is 24 bits wide
  if (INIT_CYCLES < 1 || INIT_CYCLES > 32'h00ffffff) begin : g_bad_init
    $error("prs_sequencer: INIT_CYCLES out of range");
  end

  prs_state_e  state_q, state_d;
  logic [23:0] init_cnt_q;
  logic        valid_q;
  logic        early_q;
  logic [15:0] cfg0_q, cfg1_q;

  // decoding of the hardware reset and the init countdown
  wire reset_active = ~hw_reset_n;
  wire init_done    = (init_cnt_q == 24'(INIT_CYCLES - 1));
  wire in_init      = (state_q == PRS_INIT);
  wire can_config   = (state_q == PRS_STANDBY) && !cs_n && cfg_we;
  wire refresh_run  = (state_q == PRS_INIT) || (state_q == PRS_STANDBY) ||
                      (state_q == PRS_SLEEP);

  // next state: reset dominates everything once power is present
  always_comb begin
    state_d = state_q;
    if (!supply_good) begin
      state_d = PRS_OFF;
    end else if (reset_active) begin
      // a held reset parks the machine; power-up waits here as well
      state_d = (state_q == PRS_OFF) ? PRS_OFF : PRS_HOLD;
    end else begin
      case (state_q)
        PRS_OFF:       state_d = PRS_INIT;
        PRS_HOLD:      state_d = PRS_STANDBY;
        PRS_INIT:      state_d = init_done ? PRS_STANDBY : PRS_INIT;
        PRS_STANDBY: begin
          if (deep_down_req)
            state_d = PRS_DEEP_DOWN;
          else if (sleep_req)
            state_d = PRS_SLEEP;
        end
        PRS_SLEEP:     state_d = wake_req ? PRS_STANDBY : PRS_SLEEP;
        // leaving deep power-down reinitializes like a power-up
        PRS_DEEP_DOWN: state_d = wake_req ? PRS_INIT : PRS_DEEP_DOWN;
        default:       state_d = PRS_OFF;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      state_q <= PRS_OFF;
    else
      state_q <= state_d;
  end

  // init countdown runs only in the init state, so the period starts at release
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      init_cnt_q <= 24'h000000;
    else if (!in_init)
      init_cnt_q <= 24'h000000;
    else if (!init_done)
      init_cnt_q <= init_cnt_q + 24'h000001;
  end

  // array contents: lost on reset or power loss, valid again after init
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      valid_q <= 1'b0;
    else if (reset_active || !supply_good || state_q == PRS_DEEP_DOWN)
      valid_q <= 1'b0;
    else if (in_init && init_done)
      valid_q <= 1'b1;
  end

  // flag a chip select seen outside standby and sleep; a hint only, host must avoid it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      early_q <= 1'b0;
    else
      early_q <= supply_good && !cs_n &&
                 (state_q != PRS_STANDBY) && (state_q != PRS_SLEEP);
  end

  // configuration registers return to defaults whenever reset is low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg0_q <= CFG0_RESET;
      cfg1_q <= CFG1_RESET;
    end else if (reset_active || !supply_good) begin
      cfg0_q <= CFG0_RESET;
      cfg1_q <= CFG1_RESET;
    end else if (can_config && !cfg_sel) begin
      cfg0_q <= cfg_wdata;
    end else if (can_config && cfg_sel) begin
      cfg1_q <= cfg_wdata;
    end
  end

  // refresh engine: halted and rewound while reset is low
  prs_refresh_counter #(
    .ROWS     (ROWS),
    .INTERVAL (REFRESH_INTERVAL_CYCLES)
  ) u_refresh (
    .clock         (clock),
    .rst_n         (rst_n),
    .run           (refresh_run && !reset_active),
    .restart       (reset_active || !supply_good),
    .refresh_pulse (refresh_pulse),
    .row           (refresh_row)
  );

  assign ready          = (state_q == PRS_STANDBY);
  assign array_valid    = valid_q;
  assign refresh_active = refresh_run;
  assign in_sleep       = (state_q == PRS_SLEEP);
  assign in_deep_down   = (state_q == PRS_DEEP_DOWN);
  assign early_select   = early_q;
  assign cfg0           = cfg0_q;
  assign cfg1           = cfg1_q;
endmodule : prs_sequencer
`default_nettype wire

/* File: testbench/prs_sequencer_assertions.sv */
// checker on the power-up and reset sequencer ports
`timescale 1ns/1ps
`default_nettype none
module prs_sequencer_assertions
  import prs_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = POWER_UP_INIT_CYCLES
) (
  input wire logic                     clock,
  input wire logic                     rst_n,
  input wire logic                     hw_reset_n,
  input wire logic                     ready,
  input wire logic                     array_valid,
  input wire logic                     refresh_active,
  input wire logic [prs_pkg::ROW_W-1:0] refresh_row,
  input wire logic                     in_sleep,
  input wire logic                     in_deep_down,
  input wire logic [15:0]              cfg0,
  input wire logic [15:0]              cfg1
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // init cycles seen; a counter, since the count may run to thousands
  int unsigned cnt_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      cnt_q <= 0;
    else
      cnt_q <= (refresh_active && !ready && !in_sleep) ? cnt_q + 1 : 0;
  end
  a_init_exact: assert property ($rose(ready) && cnt_q != 0 |->
    cnt_q == INIT_CYCLES) else $error("init length wrong");
  a_init_bound: assert property (cnt_q <= INIT_CYCLES)
    else $error("init overran");
  a_reset_standby: assert property (!hw_reset_n |=> !ready)
    else $error("ready during reset");
  a_reset_cfg: assert property (!hw_reset_n |=>
    cfg0 == CFG0_RESET && cfg1 == CFG1_RESET) else $error("cfg kept");
  a_reset_halt: assert property (!hw_reset_n |=>
    !refresh_active && !array_valid) else $error("refresh not halted");
  a_release_refresh: assert property ($rose(hw_reset_n) |=>
    refresh_active) else $error("refresh not resumed");
  a_reset_row: assert property (!hw_reset_n |=>
    refresh_row == ROW_RESET) else $error("row not reset");
  a_reset_wake: assert property (!hw_reset_n |=>
    !in_sleep && !in_deep_down) else $error("low power kept");
endmodule // prs_sequencer_assertions
bind prs_sequencer prs_sequencer_assertions #(
  .INIT_CYCLES    (INIT_CYCLES)
) u_prs_sequencer_assertions (
  .clock          (clock),
  .rst_n          (rst_n),
  .hw_reset_n     (hw_reset_n),
  .ready          (ready),
  .array_valid    (array_valid),
  .refresh_active (refresh_active),
  .refresh_row    (refresh_row),
  .in_sleep       (in_sleep),
  .in_deep_down   (in_deep_down),
  .cfg0           (cfg0),
  .cfg1           (cfg1)
);
`default_nettype wire

/* File: testbench/prs_host_model.sv */
// host model pacing hardware reset and chip select
`timescale 1ns/1ps
`default_nettype none
module prs_host_model (
  input  wire logic clock,
  input  wire logic rst_req,
  input  wire logic sel_req,
  input  wire logic ready,
  output var logic  hw_reset_n,
  output var logic  cs_n
);
  // cycle counters since reset fell and rose; 4 cycles is 200 ns
  int unsigned fall_q = 99;
  int unsigned rise_q = 99;
  initial hw_reset_n = 1'b1;
  initial cs_n = 1'b1;
  // pulse kept at least 4 cycles even if the request is shorter
  always @(negedge clock) begin
    fall_q <= (rst_req && hw_reset_n) ? 0 : fall_q + 1;
    rise_q <= !hw_reset_n ? 0 : rise_q + 1;
    hw_reset_n <= !(rst_req || (!hw_reset_n && fall_q < 4));
    cs_n <= !(sel_req && ready && hw_reset_n && fall_q >= 8 &&
              rise_q >= 4);
  end
endmodule // prs_host_model
`default_nettype wire

/* File: testbench/tb_prs_sequencer.sv */
// testbench for the power-up and reset sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  n_fail++; $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_prs_sequencer;
  import prs_pkg::*;
  localparam int unsigned INIT = 8;
  logic clock = 0, rst_n = 0, supply_good = 0, rst_req = 1, sel_req = 0;
  logic sleep_req = 0, deep_down_req = 0, wake_req = 0;
  logic cfg_we = 0, cfg_sel = 0, early_seen = 0;
  logic [15:0] cfg_wdata = 16'h1234, cfg0, cfg1;
  logic [ROW_W-1:0] refresh_row;
  logic hw_reset_n, cs_n, ready, array_valid, refresh_active, refresh_pulse;
  logic in_sleep, in_deep_down, early_select;
  int n_fail = 0, samples_checked = 0, n;
  always #25 clock = ~clock;
  // any early select the device flags means the host broke its waits
  always @(negedge clock)
    if (early_select === 1'b1)
      early_seen = 1'b1;
  prs_host_model u_prs_host_model (.clock, .rst_req, .sel_req, .ready,
    .hw_reset_n, .cs_n);
  prs_sequencer #(.INIT_CYCLES(INIT)) u_prs_sequencer (.clock, .rst_n,
    .supply_good, .hw_reset_n, .cs_n, .sleep_req, .deep_down_req,
    .wake_req, .cfg_we, .cfg_sel, .cfg_wdata, .ready, .array_valid,
    .refresh_active, .refresh_pulse, .refresh_row, .in_sleep,
    .in_deep_down, .early_select, .cfg0, .cfg1);
  // bounded wait for ready, n holds the cycles taken
  task automatic wait_ready;
    n = 0;
    while (ready !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
  endtask
  // reset pulse from any state, then recovery to standby
  task automatic hw_pulse;
    rst_req <= 1;
    repeat (6) @(negedge clock);
    `CHK("ready", 1'b0, ready)
    `CHK("cfg", {CFG0_RESET, CFG1_RESET}, {cfg0, cfg1})
    `CHK("refresh", 2'b00, {refresh_active, array_valid})
    `CHK("row", ROW_RESET, refresh_row)
    `CHK("modes", 2'b00, {in_sleep, in_deep_down})
    rst_req <= 0;
    wait_ready;
    `CHK("back", 2'b11, {ready, refresh_active})
  endtask
  // supply up with reset held low, init only after release
  task automatic t_power;
    supply_good = 1;
    repeat (20) @(negedge clock);
    `CHK("held", 1'b0, refresh_active | ready)
    rst_req <= 0;
    wait_ready;
    `CHK("init", 1'b1, n >= INIT && n <= INIT + 4 && array_valid)
    $display("power test done");
  endtask
  // config written and rows advanced, then lost to a reset
  task automatic t_reset;
    sel_req <= 1;
    cfg_we = 1;
    repeat (4) @(negedge clock);
    cfg_sel = 1;
    cfg_wdata = 16'h00a5;
    repeat (2) @(negedge clock);
    cfg_we = 0;
    sel_req <= 0;
    repeat (200) @(negedge clock);
    `CHK("cfg0", 16'h1234, cfg0)
    `CHK("cfg1", 16'h00a5, cfg1)
    `CHK("rows", 1'b1, refresh_row != 0)
    hw_pulse;
    $display("reset test done");
  endtask
  // pulse spacing and one row step while refreshing in standby
  task automatic t_refresh;
    logic [ROW_W-1:0] row0;
    n = 0;
    while (refresh_pulse !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    row0 = refresh_row;
    @(negedge clock);
    n = 1;
    while (refresh_pulse !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    `CHK("spacing", REFRESH_INTERVAL_CYCLES, n)
    `CHK("row step", row0 + ROW_W'(1), refresh_row)
    $display("refresh test done");
  endtask
  // wake from sleep to standby, and from deep power-down through a new init
  task automatic t_wake;
    sleep_req = 1;
    @(negedge clock);
    sleep_req = 0;
    wake_req = 1;
    @(negedge clock);
    wake_req = 0;
    `CHK("wake sleep", 2'b10, {ready, in_sleep})
    deep_down_req = 1;
    @(negedge clock);
    deep_down_req = 0;
    `CHK("deep entry", 1'b1, in_deep_down)
    wake_req = 1;
    @(negedge clock);
    wake_req = 0;
    wait_ready;
    `CHK("wake deep", 1'b1, n == INIT && array_valid)
    $display("wake test done");
  endtask
  // sleep and deep power-down, each left by a reset
  task automatic t_modes;
    sleep_req = 1;
    repeat (3) @(negedge clock);
    sleep_req = 0;
    `CHK("sleep", 1'b1, in_sleep)
    hw_pulse;
    {deep_down_req, sleep_req} = 2'b11;
    repeat (3) @(negedge clock);
    {deep_down_req, sleep_req} = 2'b00;
    `CHK("deep", 2'b01, {in_sleep, in_deep_down})
    hw_pulse;
    `CHK("early", 1'b0, early_seen)
    $display("modes test done");
  endtask
  task automatic print_verdict;
    $display("checks %0d fails %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // run far shorter than this limit; a hang ends as a failure
  initial begin
    repeat (5000) @(posedge clock);
    n_fail++;
    print_verdict;
  end
  initial begin
    repeat (20) @(negedge clock);
    rst_n = 1;
    t_power;
    t_reset;
    t_refresh;
    t_wake;
    t_modes;
    print_verdict;
  end
endmodule // tb_prs_sequencer
`default_nettype wire
